// >>> design/rbm_map.vh
// Constants for the reset boot mode selector: strap codes, counts, widths.
// Assumes inclusion by bare name from the design files only.
`ifndef RBM_MAP_VH
`define RBM_MAP_VH
// Strap vector bit positions {D,C,B,A}
`define RBM_STRAP_A 0
`define RBM_STRAP_B 1
`define RBM_STRAP_C 2
`define RBM_STRAP_D 3
// Boot mode codes (C,B,A)
`define RBM_CBA_BYTE_FULL 3'h0
`define RBM_CBA_EXT_FULL 3'h2
`define RBM_CBA_BYTE_HOST 3'h4
`define RBM_CBA_HOST_LOAD 3'h5
// Boot sizes and addresses
`define RBM_BOOT_WORDS 32
`define RBM_START_ADDR 14'h0000
`define RBM_PM_ZERO_ADDR 14'h0000
`define RBM_PORT_WIDTH 16
`endif

// >>> design/rbm_strap_latch.v
// Strap capture: samples the four mode straps while reset is held.
// Assumes straps are steady and synchronous to ref_clk_i during reset.
`timescale 1ns/1ns
module rbm_strap_latch (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Straps
  input wire [3:0] strap_i,
  // Latched value
  output reg [3:0] strap_q_o
);
  // Tracks the pin while reset is low, freezes at release
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      strap_q_o <= strap_i; // RULE1
    end
  end
endmodule // rbm_strap_latch

// >>> design/rbm_boot_count.v
// Boot word counter: counts accepted byte-memory DMA words up to a limit.
// Assumes word_i is a one-cycle pulse per word completed by the DMA engine.
`timescale 1ns/1ns
`include "rbm_map.vh"
module rbm_boot_count #(
  parameter WORDS = `RBM_BOOT_WORDS
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Control
  input wire run_i,
  input wire word_i,
  // Status
  output reg done_o
);
  reg [6:0] cnt_q;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 7'h00;
      done_o <= 1'b0;
    end else if (run_i && word_i && !done_o) begin
      cnt_q <= cnt_q + 7'h01;
      if (cnt_q == WORDS - 1) begin
        done_o <= 1'b1; // RULE2
      end
    end
  end
endmodule // rbm_boot_count

// >>> design/rbm_boot_select.v
// Reset boot mode selector: decodes latched straps into memory mode,
// boot source, execution hold and host ack drive style.
// Assumes a DMA engine pulses a word strobe per boot word and reports
// host writes to internal program memory with their address.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "rbm_map.vh"
// What this block does
// RULE1 - The memory mode strap is sampled while reset is low and held after release.
// RULE2 - Straps C=0,B=0,A=0 boot 32 words by byte memory DMA, hold execution, full memory mode.
// RULE3 - Straps C=0,B=1,A=0 start at external address 0 with no boot in full memory mode.
// RULE4 - Straps C=1,B=0,A=0 boot 32 words by byte memory DMA in host mode.
// RULE5 - Straps C=1,B=0,A=1 hold execution in host mode until the host writes program word 0.
// RULE6 - In host mode strap D=0 drives the ack actively and D=1 makes it open drain.
// RULE7 - Host mode swaps the external bus for the 16-bit internal memory DMA port.
// RULE8 - An external strap driver drives the shared pin only while reset is low.
// RULE9 - After reset the shared pin returns to use as a programmable flag.
// RULE10 - Undocumented strap codes fall back to host mode with no automatic boot.
module rbm_boot_select (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Strap pins; C shares the flag pin
  input wire strap_a_i,
  input wire strap_b_i,
  input wire shared_flag_pin_two_i,
  input wire strap_d_i,
  // Flag function of the shared pin
  input wire flag_dir_out_i,
  input wire flag_out_i,
  output reg shared_flag_pin_two_o,
  output reg shared_flag_pin_two_oe_o,
  output reg flag_in_o,
  // Byte memory DMA boot
  input wire byte_memory_dma_word_i,
  output reg byte_memory_dma_boot_o,
  output reg boot_done_o,
  // Host writes to internal memory
  input wire host_pm_write_i,
  input wire [13:0] host_pm_addr_i,
  // Host acknowledge
  input wire host_access_ack_i,
  output reg host_access_ack_o,
  output reg host_access_ack_oe_o,
  // Configuration results
  output reg host_mode_o,
  output reg internal_memory_dma_port_en_o,
  output reg ext_bus_en_o,
  output reg run_o,
  output reg [13:0] start_addr_o
);
  wire [3:0] strap_w;
  wire [3:0] strap_q;
  wire cnt_done;
  wire [2:0] cba;
  reg byte_boot;
  reg host_load;
  reg host_cfg;
  reg host_seen_q;
  reg released_q;

  // Execution release: byte boot waits on the count, host load on word 0
  function release_now;
    input byte_b;
    input load_b;
    input done_b;
    input seen_b;
    begin
      release_now = byte_b ? done_b : (load_b ? seen_b : 1'b1);
    end
  endfunction

  assign strap_w = {strap_d_i, shared_flag_pin_two_i, strap_b_i, strap_a_i};
  assign cba = {strap_q[`RBM_STRAP_C], strap_q[`RBM_STRAP_B], strap_q[`RBM_STRAP_A]};

  rbm_strap_latch u_latch (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .strap_i(strap_w),
    .strap_q_o(strap_q)
  );

  rbm_boot_count #(.WORDS(`RBM_BOOT_WORDS)) u_count (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(byte_boot),
    .word_i(byte_memory_dma_word_i),
    .done_o(cnt_done)
  );

  // Mode decode from latched straps
  always @* begin
    byte_boot = 1'b0;
    host_load = 1'b0;
    host_cfg = 1'b1; // RULE10
    case (cba)
      `RBM_CBA_BYTE_FULL: begin
        byte_boot = 1'b1; // RULE2
        host_cfg = 1'b0;
      end
      `RBM_CBA_EXT_FULL: begin
        host_cfg = 1'b0; // RULE3
      end
      `RBM_CBA_BYTE_HOST: begin
        byte_boot = 1'b1; // RULE4
      end
      `RBM_CBA_HOST_LOAD: begin
        host_load = 1'b1; // RULE5
      end
      default: begin
        host_cfg = 1'b1; // RULE10
      end
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      host_seen_q <= 1'b0;
      released_q <= 1'b0;
      shared_flag_pin_two_o <= 1'b0;
      shared_flag_pin_two_oe_o <= 1'b0;
      flag_in_o <= 1'b0;
      byte_memory_dma_boot_o <= 1'b0;
      boot_done_o <= 1'b0;
      host_access_ack_o <= 1'b0;
      host_access_ack_oe_o <= 1'b0;
      host_mode_o <= 1'b0;
      internal_memory_dma_port_en_o <= 1'b0;
      ext_bus_en_o <= 1'b0;
      run_o <= 1'b0;
      start_addr_o <= `RBM_START_ADDR;
    end else begin
      released_q <= 1'b1;
      // Pin stays undriven in reset so a strap driver can own it
      shared_flag_pin_two_oe_o <= released_q & flag_dir_out_i; // RULE9 RULE8
      shared_flag_pin_two_o <= flag_out_i; // RULE9
      flag_in_o <= shared_flag_pin_two_i; // RULE9
      if (host_load && host_pm_write_i && host_pm_addr_i == `RBM_PM_ZERO_ADDR) begin
        host_seen_q <= 1'b1; // RULE5
      end
      host_mode_o <= host_cfg;
      internal_memory_dma_port_en_o <= host_cfg; // RULE7
      ext_bus_en_o <= ~host_cfg; // RULE7
      byte_memory_dma_boot_o <= byte_boot & ~cnt_done; // RULE2 RULE4
      boot_done_o <= release_now(byte_boot, host_load, cnt_done, host_seen_q); // RULE2
      run_o <= release_now(byte_boot, host_load, cnt_done, host_seen_q); // RULE2 RULE3 RULE5
      start_addr_o <= `RBM_START_ADDR; // RULE3
      // Ack: active low; open drain drives only the low level
      if (host_cfg) begin
        host_access_ack_o <= host_access_ack_i;
        if (strap_q[`RBM_STRAP_D]) begin
          host_access_ack_oe_o <= ~host_access_ack_i; // RULE6
        end else begin
          host_access_ack_oe_o <= 1'b1; // RULE6
        end
      end else begin
        host_access_ack_o <= 1'b0;
        host_access_ack_oe_o <= 1'b0;
      end
    end
  end
endmodule // rbm_boot_select

// >>> test/rbm_checker.sv
// Port checker for the boot mode selector.
// Assumes it is bound onto rbm_boot_select with one clock.
`timescale 1ns/1ns
module rbm_checker (
  // Clock, reset, straps
  input wire ref_clk_i,
  input wire rstn_i,
  input wire strap_a_i,
  input wire strap_b_i,
  input wire shared_flag_pin_two_i,
  input wire strap_d_i,
  // Far side inputs
  input wire flag_dir_out_i,
  input wire flag_out_i,
  input wire byte_memory_dma_word_i,
  input wire host_pm_write_i,
  input wire [13:0] host_pm_addr_i,
  input wire host_access_ack_i,
  // Results
  input wire shared_flag_pin_two_o,
  input wire flag_in_o,
  input wire byte_memory_dma_boot_o,
  input wire boot_done_o,
  input wire host_access_ack_o,
  input wire shared_flag_pin_two_oe_o,
  input wire host_access_ack_oe_o,
  input wire host_mode_o,
  input wire internal_memory_dma_port_en_o,
  input wire ext_bus_en_o,
  input wire run_o,
  input wire [13:0] start_addr_o
);
  reg [3:0] m_q;
  reg [5:0] n_q;
  reg s_q;
  wire h = m_q[2] | m_q[0];
  wire bt = m_q[1:0] == 2'h0;
  wire hl = m_q[2:0] == 3'h5;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      m_q <= {strap_d_i, shared_flag_pin_two_i, strap_b_i, strap_a_i};
      n_q <= 6'h00;
      s_q <= 1'b0;
    end else begin
      if (byte_memory_dma_word_i && n_q != 6'h20) n_q <= n_q + 6'h01;
      if (host_pm_write_i && host_pm_addr_i == 14'h0000) s_q <= 1'b1;
    end
  end
  a_mode_decode: assert property (
    $past(rstn_i) |-> {host_mode_o, ext_bus_en_o, internal_memory_dma_port_en_o} == {h, !h, h})
    else $error("mode outputs wrong");
  a_start_zero: assert property (start_addr_o == 14'h0000) else $error("start address");
  a_pin_quiet: assert property (
    disable iff (1'b0) !rstn_i |=> !shared_flag_pin_two_oe_o) else $error("pin driven in reset");
  a_pin_flag: assert property (
    $past(rstn_i, 2) && $past(rstn_i) |-> shared_flag_pin_two_oe_o == $past(flag_dir_out_i))
    else $error("flag direction");
  a_run_early: assert property (
    $past(rstn_i) && !bt && !hl |-> run_o) else $error("no-boot run late");
  a_hold_boot: assert property ((bt && run_o) |-> n_q == 6'h20) else $error("run early");
  a_boot_release: assert property (
    bt && byte_memory_dma_word_i && n_q == 6'h1F |-> ##[1:3] run_o) else $error("boot end");
  a_host_hold: assert property (hl && run_o |-> s_q) else $error("host hold");
  a_ack_drive: assert property (
    $past(rstn_i) |-> host_access_ack_oe_o == (h && (!m_q[3] || !$past(host_access_ack_i))))
    else $error("ack drive");
  a_done_run: assert property ($past(rstn_i) |-> boot_done_o == run_o) else $error("done");
  a_boot_busy: assert property (
    $past(rstn_i) |-> byte_memory_dma_boot_o == (bt && !run_o)) else $error("boot busy");
  a_flag_echo: assert property (
    $past(rstn_i) |-> flag_in_o == $past(shared_flag_pin_two_i)
      && shared_flag_pin_two_o == $past(flag_out_i)) else $error("flag echo");
  a_ack_level: assert property (
    $past(rstn_i) |-> host_access_ack_o == (h && $past(host_access_ack_i)))
    else $error("ack level");
  c_byte_boot: cover property (bt && run_o);
  c_host_load: cover property (hl && run_o);
  c_ack_open: cover property (h && m_q[3] && host_access_ack_oe_o);
endmodule // rbm_checker
bind rbm_boot_select rbm_checker u_chk (.*);

// >>> test/rbm_far_end.sv
// Far side model: byte memory boot source, host writer, strap driver.
// Assumes its plan inputs are steady while reset is low.
`timescale 1ns/1ns
module rbm_far_end (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Plan
  input wire [5:0] words_i,
  input wire host_i,
  input wire [1:0] gap_i,
  // Far side pins
  output reg word_o,
  output reg wr_o,
  output reg [13:0] addr_o,
  output wire strap_oe_o
);
  reg [5:0] n_q;
  reg [1:0] g_q;
  assign strap_oe_o = !rstn_i;
  always @(posedge ref_clk_i) begin
    word_o <= 1'b0;
    wr_o <= 1'b0;
    // Idle address toggles so a stale value is never trusted
    addr_o <= ~addr_o;
    if (!rstn_i) begin
      n_q <= words_i;
      g_q <= 2'h0;
      addr_o <= 14'h3FFF;
    end else if (g_q != 2'h0) g_q <= g_q - 2'h1;
    else if (n_q != 6'h00) begin
      n_q <= n_q - 6'h01;
      g_q <= gap_i;
      word_o <= !host_i;
      wr_o <= host_i;
      addr_o <= {13'h0000, n_q != 6'h01};
    end
  end
endmodule // rbm_far_end

// >>> test/tb_rbm_boot_select.sv
// Bench: all sixteen strap codes through reset, boot and release.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tb_rbm_boot_select;
  reg ref_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg [3:0] k_q = 4'h0;
  reg [1:0] gap_q = 2'h0;
  reg [2:0] rnd_q = 3'h0;
  reg seen_q = 1'b0;
  reg [15:0] cyc_q = 16'h0000;
  reg [3:0] exp_v;
  reg [3:0] note_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int tick = 0;
  wire wd, wr, soe, oe, po, run, hm, ext, idm;
  wire [13:0] ad;
  // Released strap line floats: show the inverse of its last level
  wire pin = oe ? po : (soe ? k_q[2] : !k_q[2]);
  wire hl = k_q[2:0] == 3'h5;
  rbm_far_end u_far (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .words_i(hl ? 6'h03 : 6'h22),
    .host_i(hl), .gap_i(gap_q), .word_o(wd), .wr_o(wr), .addr_o(ad), .strap_oe_o(soe));
  rbm_boot_select u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .strap_a_i(k_q[0]),
    .strap_b_i(k_q[1]), .shared_flag_pin_two_i(pin), .strap_d_i(k_q[3]),
    .flag_dir_out_i(rnd_q[0]), .flag_out_i(rnd_q[1]), .shared_flag_pin_two_o(po),
    .shared_flag_pin_two_oe_o(oe), .flag_in_o(), .byte_memory_dma_word_i(wd),
    .byte_memory_dma_boot_o(), .boot_done_o(), .host_pm_write_i(wr), .host_pm_addr_i(ad),
    .host_access_ack_i(rnd_q[2]), .host_access_ack_o(), .host_access_ack_oe_o(),
    .host_mode_o(hm), .internal_memory_dma_port_en_o(idm), .ext_bus_en_o(ext),
    .run_o(run), .start_addr_o());
  task give_verdict;
    $display("Errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) rnd_q <= 3'($urandom);
  always @(posedge ref_clk_i) begin
    cyc_q <= rstn_i ? cyc_q + 16'h0001 : 16'h0000;
    seen_q <= rstn_i && (seen_q || run === 1'b1);
    if (rstn_i && run === 1'b1 && !seen_q && note_q.size() != 0) begin
      exp_v = note_q.pop_front();
      `CHK("mode", exp_v, {hm, ext, idm, cyc_q < 16'h0003})
    end
    tick++;
    if (tick > 5000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(32'hDD15));
    for (int k = 0; k < 16; k++) begin
      rstn_i <= 1'b0;
      k_q <= 4'(k);
      gap_q <= 2'($urandom);
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      note_q.push_back({k[2] | k[0], !(k[2] | k[0]), k[2] | k[0],
        k[1:0] != 2'h0 && k[2:0] != 3'h5});
      for (int w = 0; w < 300 && run !== 1'b1; w++) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
    end
    `CHK("unanswered", 0, note_q.size())
    give_verdict;
  end
endmodule // tb_rbm_boot_select
